/* File: hdl/mac_pkg.sv */
// Purpose: Shared constants and types for the 16-bit full-duplex Ethernet MAC.
// Assumes: Frames arrive word aligned, first wire byte in bits 7:0.
// Notes:   Config byte offsets apply to the 8-bit configuration write port.
package mac_pkg;

  // ----------------------------------------------------------------------
  // Frame framing on the 16-bit link
  // ----------------------------------------------------------------------
  localparam logic [15:0] PRE_WORD     = 16'h5555;
  localparam logic [15:0] SFD_WORD     = 16'hd555;
  localparam logic [15:0] PRE_WORDS    = 16'h0004;
  localparam logic [15:0] MIN_RX_WORDS = 16'h0020;
  localparam logic [15:0] MIN_TX_WORDS = 16'h001e;
  localparam logic [15:0] FCS_WORDS    = 16'h0002;
  localparam logic [15:0] DA_WORDS     = 16'h0003;
  localparam logic [15:0] TYPE_IDX     = 16'h0006;
  localparam logic [15:0] OP_IDX       = 16'h0007;
  localparam logic [15:0] QUANTA_IDX   = 16'h0008;
  localparam logic [15:0] VLAN_TPID    = 16'h0081;
  localparam logic [15:0] PAUSE_TYPE   = 16'h0888;
  localparam logic [15:0] PAUSE_OP     = 16'h0100;
  localparam logic [47:0] PAUSE_DA     = 48'h0100_00c2_8001;
  localparam logic [47:0] BCAST_DA     = 48'hffff_ffff_ffff;
  localparam int          QUANTUM_LSB  = 5;

  // ----------------------------------------------------------------------
  // CRC-32, reflected form
  // ----------------------------------------------------------------------
  localparam logic [31:0] CRC_INIT    = 32'hffff_ffff;
  localparam logic [31:0] CRC_POLY    = 32'hedb8_8320;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb_20e3;

  // ----------------------------------------------------------------------
  // Receive buffer and configuration bytes
  // ----------------------------------------------------------------------
  localparam int          BUF_AW     = 6;
  localparam logic [5:0]  HOLD_WORDS = 6'h20;
  localparam int          CFG_BYTES  = 16;
  localparam int          CFG_MAC0   = 0;
  localparam int          CFG_CTRL   = 6;
  localparam int          CFG_IPG    = 7;
  localparam int          CFG_MCAST0 = 8;
  localparam int          CTRL_PROMISC  = 0;
  localparam int          CTRL_MCAST_EN = 1;
  localparam int          CTRL_RX_PASS  = 2;
  localparam int          CTRL_TX_GEN   = 3;
  localparam int          CTRL_TX_PAD   = 4;
  localparam logic [7:0]  CTRL_RST   = 8'h18;
  localparam logic [7:0]  IPG_RST    = 8'h06;
  localparam int          STAT_W     = 22;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_PRE = 2'b01, RX_DATA = 2'b11, RX_DROP = 2'b10
  } rx_state_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_PRE = 3'b001, TX_DATA = 3'b011,
    TX_PAD  = 3'b010, TX_FCS = 3'b110, TX_IPG  = 3'b111
  } tx_state_t;

endpackage

/* File: hdl/crc_if.sv */
// Purpose: Carries one CRC engine's controls, data word and result.
// Assumes: All signals belong to the link clock domain.
// Notes:   The engine updates on the edge after en is seen.
`timescale 1ns/100ps
interface crc_if;
  logic        init;
  logic        en;
  logic [15:0] data;
  logic [31:0] crc;
  modport eng  (input init, input en, input data, output crc);
  modport user (output init, output en, output data, input crc);
endinterface // crc_if

/* File: hdl/crc32_w16.sv */
// Purpose: Running CRC-32 over 16-bit words, low byte first, LSB first.
// Assumes: Synchronous active-high reset on the link clock.
// Notes:   Result is the raw register; callers invert it for the FCS.
`timescale 1ns/100ps
module crc32_w16 (
  input  wire logic clk,
  input  wire logic rst,
  crc_if.eng        c
);

  logic [31:0] crc_q;

  function automatic logic [31:0] next_crc(input logic [31:0] cur, input logic [15:0] d);
    logic [31:0] r;
    r = cur;
    for (int i = 0; i < 16; i++) begin
      r = {1'b0, r[31:1]} ^ (mac_pkg::CRC_POLY & {32{r[0] ^ d[i]}});
    end
    return r;
  endfunction

  always_ff @(posedge clk) begin
    if (rst || c.init) begin
      crc_q <= mac_pkg::CRC_INIT;
    end else if (c.en) begin
      crc_q <= next_crc(crc_q, c.data);
    end
  end

  assign c.crc = crc_q;

endmodule // crc32_w16

/* File: hdl/eth_mac16_top.sv */
// Purpose: Full-duplex Ethernet MAC, 16-bit link side, client FIFO side.
// Assumes: Link and client streams run on gmii_clk; config on clk.
// Notes:   Frames are taken as an even number of bytes.
`timescale 1ns/100ps
module eth_mac16_top (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       cfg_wr,
  input  wire logic [3:0]                 cfg_addr,
  input  wire logic [7:0]                 cfg_wdata,
  output logic                            stat_valid,
  output logic [mac_pkg::STAT_W-1:0]      stat_vec,
  input  wire logic                       gmii_clk,
  input  wire logic [15:0]                gmii_rxd,
  input  wire logic                       gmii_rx_dv,
  input  wire logic                       gmii_rx_er,
  output logic [15:0]                     gmii_txd,
  output logic                            gmii_tx_en,
  output logic                            gmii_tx_er,
  output logic                            rx_wr,
  output logic [15:0]                     rx_data,
  output logic                            rx_eof,
  output logic                            rx_err,
  input  wire logic                       tx_pkt_avail,
  input  wire logic [15:0]                tx_data,
  input  wire logic                       tx_eof,
  output logic                            tx_rd
);

  // ----------------------------------------------------------------------
  // Configuration bytes, system clock domain
  // ----------------------------------------------------------------------
  logic [7:0]                       cfg_q [mac_pkg::CFG_BYTES];
  logic [8*mac_pkg::CFG_BYTES-1:0]  cfg_flat;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < mac_pkg::CFG_BYTES; i++) begin
        cfg_q[i] <= (i == mac_pkg::CFG_CTRL) ? mac_pkg::CTRL_RST :
                    (i == mac_pkg::CFG_IPG)  ? mac_pkg::IPG_RST  : 8'h00;
      end
    end else if (cfg_wr) begin
      cfg_q[cfg_addr] <= cfg_wdata;
    end
  end

  for (genvar g = 0; g < mac_pkg::CFG_BYTES; g++) begin : g_cfg
    assign cfg_flat[8*g +: 8] = cfg_q[g];
  end

  // ----------------------------------------------------------------------
  // Crossings into the link domain
  // ----------------------------------------------------------------------
  // Config is quasi-static, so a plain two-stage copy is enough; software
  // must change it only while the link is quiet.
  logic                             lrst_s1_q, lrst_s2_q, link_rst;
  logic [8*mac_pkg::CFG_BYTES-1:0]  cfg_s1_q, cfg_s2_q;

  always_ff @(posedge gmii_clk) begin
    lrst_s1_q <= sys_rst;
    lrst_s2_q <= lrst_s1_q;
    cfg_s1_q  <= cfg_flat;
    cfg_s2_q  <= cfg_s1_q;
  end

  assign link_rst = lrst_s2_q;

  logic [47:0] station;
  logic [7:0]  ctrl;
  logic [7:0]  ipg;
  logic [63:0] mcast_tbl;
  assign station   = cfg_s2_q[8*mac_pkg::CFG_MAC0 +: 48];
  assign ctrl      = cfg_s2_q[8*mac_pkg::CFG_CTRL +: 8];
  assign ipg       = cfg_s2_q[8*mac_pkg::CFG_IPG +: 8];
  assign mcast_tbl = cfg_s2_q[8*mac_pkg::CFG_MCAST0 +: 64];

  // ----------------------------------------------------------------------
  // Receive framing
  // ----------------------------------------------------------------------
  mac_pkg::rx_state_t rx_state_q;
  logic [15:0]        wcnt_q;
  logic [47:0]        da_q;
  logic [5:0]         hash_q;
  logic               vlan_q, ptype_q, pop_q, er_q;
  logic [15:0]        quanta_q;
  logic               rx_end, rx_keep, addr_ok, runt, crc_ok, bcast, mcast;
  crc_if              rxc ();

  assign rxc.init = (rx_state_q == mac_pkg::RX_PRE);
  assign rxc.en   = (rx_state_q == mac_pkg::RX_DATA) && gmii_rx_dv;
  assign rxc.data = gmii_rxd;

  crc32_w16 u_rx_crc (.clk(gmii_clk), .rst(link_rst), .c(rxc));

  always_ff @(posedge gmii_clk) begin
    if (link_rst) begin
      rx_state_q <= mac_pkg::RX_IDLE;
    end else begin
      case (rx_state_q)
        mac_pkg::RX_IDLE: if (gmii_rx_dv) begin
          rx_state_q <= (gmii_rxd == mac_pkg::PRE_WORD) ? mac_pkg::RX_PRE : mac_pkg::RX_DROP;
        end
        mac_pkg::RX_PRE: begin
          if (!gmii_rx_dv) begin
            rx_state_q <= mac_pkg::RX_IDLE;
          end else if (gmii_rxd == mac_pkg::SFD_WORD) begin
            rx_state_q <= mac_pkg::RX_DATA;
          end else if (gmii_rxd != mac_pkg::PRE_WORD) begin
            rx_state_q <= mac_pkg::RX_DROP;
          end
        end
        mac_pkg::RX_DATA, mac_pkg::RX_DROP: if (!gmii_rx_dv) begin
          rx_state_q <= mac_pkg::RX_IDLE;
        end
        default: rx_state_q <= mac_pkg::RX_IDLE;
      endcase
    end
  end

  // Header fields are caught by word index as they pass.
  always_ff @(posedge gmii_clk) begin
    if (link_rst || rx_state_q == mac_pkg::RX_PRE) begin
      wcnt_q   <= 16'h0000;
      da_q     <= 48'h0000_0000_0000;
      hash_q   <= 6'h00;
      vlan_q   <= 1'b0;
      ptype_q  <= 1'b0;
      pop_q    <= 1'b0;
      er_q     <= 1'b0;
      quanta_q <= 16'h0000;
    end else if (rxc.en) begin
      if (wcnt_q != 16'hffff) begin
        wcnt_q <= wcnt_q + 16'h0001;
      end
      if (wcnt_q < mac_pkg::DA_WORDS) begin
        da_q[16*wcnt_q[1:0] +: 16] <= gmii_rxd;
      end
      if (wcnt_q == mac_pkg::DA_WORDS) begin
        hash_q <= rxc.crc[31:26];
      end
      if (wcnt_q == mac_pkg::TYPE_IDX) begin
        vlan_q  <= (gmii_rxd == mac_pkg::VLAN_TPID);
        ptype_q <= (gmii_rxd == mac_pkg::PAUSE_TYPE);
      end
      if (wcnt_q == mac_pkg::OP_IDX) begin
        pop_q <= (gmii_rxd == mac_pkg::PAUSE_OP);
      end
      if (wcnt_q == mac_pkg::QUANTA_IDX) begin
        quanta_q <= {gmii_rxd[7:0], gmii_rxd[15:8]};
      end
      if (gmii_rx_er) begin
        er_q <= 1'b1;
      end
    end
  end

  assign bcast   = (da_q == mac_pkg::BCAST_DA);
  assign mcast   = da_q[0] && !bcast;
  assign addr_ok = ctrl[mac_pkg::CTRL_PROMISC] || (da_q == station) || bcast ||
                   (mcast && ctrl[mac_pkg::CTRL_MCAST_EN] && mcast_tbl[hash_q]);
  assign runt    = (wcnt_q < mac_pkg::MIN_RX_WORDS);
  assign crc_ok  = (rxc.crc == mac_pkg::CRC_RESIDUE);
  assign rx_end  = (rx_state_q == mac_pkg::RX_DATA) && !gmii_rx_dv;
  assign rx_keep = addr_ok && !runt;

  // ----------------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------------
  // Words lag HOLD_WORDS behind the link, so a frame is never seen by the
  // client before it is known to be no runt and to pass the address check.
  logic [15:0]               rx_mem [2**mac_pkg::BUF_AW];
  logic [mac_pkg::BUF_AW-1:0] wptr_q, sof_ptr_q, rptr_q, end_ptr_q, skip_ptr_q, fill;
  logic                      done_q, fin_err_q, rd_fire, rd_last, rd_stream;

  always_ff @(posedge gmii_clk) begin
    if (rxc.en) begin
      rx_mem[wptr_q] <= gmii_rxd;
    end
  end

  always_ff @(posedge gmii_clk) begin
    if (link_rst) begin
      wptr_q    <= '0;
      sof_ptr_q <= '0;
    end else if (rxc.en) begin
      wptr_q <= wptr_q + 1'b1;
    end else if (rx_end && !rx_keep) begin
      wptr_q <= sof_ptr_q;
    end else if (rx_state_q == mac_pkg::RX_PRE) begin
      sof_ptr_q <= wptr_q;
    end
  end

  assign fill      = wptr_q - rptr_q;
  assign rd_stream = (rx_state_q == mac_pkg::RX_DATA) && addr_ok && (fill > mac_pkg::HOLD_WORDS);
  assign rd_fire   = done_q ? (rptr_q != end_ptr_q) : rd_stream;
  assign rd_last   = done_q && (rptr_q + 1'b1 == end_ptr_q);

  always_ff @(posedge gmii_clk) begin
    if (link_rst) begin
      rptr_q     <= '0;
      done_q     <= 1'b0;
      end_ptr_q  <= '0;
      skip_ptr_q <= '0;
      fin_err_q  <= 1'b0;
    end else begin
      if (rd_last) begin
        rptr_q <= skip_ptr_q;
        done_q <= 1'b0;
      end else if (rd_fire) begin
        rptr_q <= rptr_q + 1'b1;
      end
      if (rx_end && rx_keep) begin
        done_q     <= 1'b1;
        end_ptr_q  <= ctrl[mac_pkg::CTRL_RX_PASS] ? wptr_q :
                      wptr_q - mac_pkg::FCS_WORDS[mac_pkg::BUF_AW-1:0];
        skip_ptr_q <= wptr_q;
        fin_err_q  <= !crc_ok || er_q;
      end
    end
  end

  always_ff @(posedge gmii_clk) begin
    if (link_rst) begin
      rx_wr   <= 1'b0;
      rx_data <= 16'h0000;
      rx_eof  <= 1'b0;
      rx_err  <= 1'b0;
    end else begin
      rx_wr   <= rd_fire;
      rx_data <= rx_mem[rptr_q];
      rx_eof  <= rd_last;
      rx_err  <= rd_last && fin_err_q;
    end
  end

  // ----------------------------------------------------------------------
  // Statistics and pause detection
  // ----------------------------------------------------------------------
  logic [mac_pkg::STAT_W-1:0] stat_hold_q;
  logic                       stat_tgl_q, pause_ld_q, ts1_q, ts2_q, ts3_q;

  always_ff @(posedge gmii_clk) begin
    if (link_rst) begin
      stat_hold_q <= '0;
      stat_tgl_q  <= 1'b0;
      pause_ld_q  <= 1'b0;
    end else begin
      pause_ld_q <= rx_end && crc_ok && (da_q == mac_pkg::PAUSE_DA) && ptype_q && pop_q;
      if (rx_end) begin
        stat_hold_q <= {wcnt_q[14:0], 1'b0, er_q, vlan_q, ptype_q && pop_q,
                        mcast, bcast, crc_ok};
        stat_tgl_q  <= !stat_tgl_q;
      end
    end
  end

  // The held vector stays put for a whole frame, far longer than the
  // toggle takes to cross, so it is safe to sample on the toggle edge.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ts1_q      <= 1'b0;
      ts2_q      <= 1'b0;
      ts3_q      <= 1'b0;
      stat_valid <= 1'b0;
      stat_vec   <= '0;
    end else begin
      ts1_q      <= stat_tgl_q;
      ts2_q      <= ts1_q;
      ts3_q      <= ts2_q;
      stat_valid <= ts2_q ^ ts3_q;
      if (ts2_q ^ ts3_q) begin
        stat_vec <= stat_hold_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transmit
  // ----------------------------------------------------------------------
  mac_pkg::tx_state_t tx_state_q;
  logic [15:0]        tx_cnt_q, tx_cnt_n, tx_word;
  logic [20:0]        pause_cnt_q;
  logic               gen_fcs, pad_en;
  crc_if              txc ();

  assign gen_fcs  = ctrl[mac_pkg::CTRL_TX_GEN];
  assign pad_en   = ctrl[mac_pkg::CTRL_TX_PAD] && gen_fcs;
  assign tx_cnt_n = tx_cnt_q + 16'h0001;
  assign tx_rd    = (tx_state_q == mac_pkg::TX_DATA);

  always_comb begin
    case (tx_state_q)
      mac_pkg::TX_PRE:  tx_word = (tx_cnt_n == mac_pkg::PRE_WORDS) ? mac_pkg::SFD_WORD
                                                                    : mac_pkg::PRE_WORD;
      mac_pkg::TX_DATA: tx_word = tx_data;
      mac_pkg::TX_FCS:  tx_word = (tx_cnt_q == 16'h0000) ? ~txc.crc[15:0] : ~txc.crc[31:16];
      default:          tx_word = 16'h0000;
    endcase
  end

  assign txc.init = (tx_state_q == mac_pkg::TX_PRE);
  assign txc.en   = (tx_state_q == mac_pkg::TX_DATA) || (tx_state_q == mac_pkg::TX_PAD);
  assign txc.data = tx_word;

  crc32_w16 u_tx_crc (.clk(gmii_clk), .rst(link_rst), .c(txc));

  always_ff @(posedge gmii_clk) begin
    if (link_rst) begin
      tx_state_q <= mac_pkg::TX_IDLE;
      tx_cnt_q   <= 16'h0000;
    end else begin
      tx_cnt_q <= (tx_cnt_q == 16'hffff) ? tx_cnt_q : tx_cnt_n;
      case (tx_state_q)
        mac_pkg::TX_IDLE: begin
          tx_cnt_q <= 16'h0000;
          if (tx_pkt_avail && pause_cnt_q == 21'h000000) begin
            tx_state_q <= mac_pkg::TX_PRE;
          end
        end
        mac_pkg::TX_PRE: if (tx_cnt_n == mac_pkg::PRE_WORDS) begin
          tx_state_q <= mac_pkg::TX_DATA;
          tx_cnt_q   <= 16'h0000;
        end
        mac_pkg::TX_DATA: if (tx_eof) begin
          if (pad_en && tx_cnt_n < mac_pkg::MIN_TX_WORDS) begin
            tx_state_q <= mac_pkg::TX_PAD;
          end else begin
            tx_state_q <= gen_fcs ? mac_pkg::TX_FCS : mac_pkg::TX_IPG;
            tx_cnt_q   <= 16'h0000;
          end
        end
        mac_pkg::TX_PAD: if (tx_cnt_n == mac_pkg::MIN_TX_WORDS) begin
          tx_state_q <= mac_pkg::TX_FCS;
          tx_cnt_q   <= 16'h0000;
        end
        mac_pkg::TX_FCS: if (tx_cnt_n == mac_pkg::FCS_WORDS) begin
          tx_state_q <= mac_pkg::TX_IPG;
          tx_cnt_q   <= 16'h0000;
        end
        mac_pkg::TX_IPG: if (tx_cnt_n >= {8'h00, ipg}) begin
          tx_state_q <= mac_pkg::TX_IDLE;
        end
        default: tx_state_q <= mac_pkg::TX_IDLE;
      endcase
    end
  end

  // A pause quantum is 512 bit times, i.e. 32 words on this link.
  always_ff @(posedge gmii_clk) begin
    if (link_rst) begin
      pause_cnt_q <= 21'h000000;
    end else if (pause_ld_q) begin
      pause_cnt_q <= 21'(quanta_q) << mac_pkg::QUANTUM_LSB;
    end else if (pause_cnt_q != 21'h000000) begin
      pause_cnt_q <= pause_cnt_q - 21'h000001;
    end
  end

  always_ff @(posedge gmii_clk) begin
    if (link_rst) begin
      gmii_txd   <= 16'h0000;
      gmii_tx_en <= 1'b0;
      gmii_tx_er <= 1'b0;
    end else begin
      gmii_txd   <= tx_word;
      gmii_tx_en <= (tx_state_q != mac_pkg::TX_IDLE) && (tx_state_q != mac_pkg::TX_IPG);
      gmii_tx_er <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_pre_words;
    (gmii_tx_en && gmii_txd == mac_pkg::PRE_WORD) [*3]
    ##1 (gmii_tx_en && gmii_txd == mac_pkg::SFD_WORD);
  endsequence

  sequence s_tx_launch;
    (tx_state_q == mac_pkg::TX_IDLE) ##1 (tx_state_q == mac_pkg::TX_PRE);
  endsequence

  a_tx_start_gate: assert property (@(posedge gmii_clk) disable iff (link_rst)
    (tx_state_q == mac_pkg::TX_IDLE && !tx_pkt_avail) |=> tx_state_q == mac_pkg::TX_IDLE)
    else $error("transmit left idle without a packet");
  a_tx_preamble_out: assert property (@(posedge gmii_clk) disable iff (link_rst)
    s_tx_launch |=> s_pre_words)
    else $error("preamble or SFD words wrong");
  a_tx_fcs_len: assert property (@(posedge gmii_clk) disable iff (link_rst)
    (tx_state_q == mac_pkg::TX_FCS && tx_cnt_q == 16'h0000)
    |=> tx_state_q == mac_pkg::TX_FCS ##1 tx_state_q == mac_pkg::TX_IPG)
    else $error("FCS not two words long");
  a_tx_pad_min: assert property (@(posedge gmii_clk) disable iff (link_rst)
    (tx_state_q == mac_pkg::TX_PAD && tx_cnt_n == mac_pkg::MIN_TX_WORDS)
    |=> tx_state_q == mac_pkg::TX_FCS && $past(tx_cnt_q) == mac_pkg::MIN_TX_WORDS - 16'h0001)
    else $error("pad did not end at minimum length");
  a_tx_gap_hold: assert property (@(posedge gmii_clk) disable iff (link_rst)
    (tx_state_q == mac_pkg::TX_IPG && tx_cnt_n < {8'h00, ipg})
    |=> tx_state_q == mac_pkg::TX_IPG && !gmii_tx_en)
    else $error("inter-frame gap cut short");
  a_pause_hold: assert property (@(posedge gmii_clk) disable iff (link_rst)
    (tx_state_q == mac_pkg::TX_IDLE && pause_cnt_q != 21'h000000)
    |=> tx_state_q == mac_pkg::TX_IDLE)
    else $error("frame started during pause");
  a_rx_sfd_start: assert property (@(posedge gmii_clk) disable iff (link_rst)
    (rx_state_q == mac_pkg::RX_PRE && gmii_rx_dv && gmii_rxd == mac_pkg::SFD_WORD)
    |=> rx_state_q == mac_pkg::RX_DATA && wcnt_q == 16'h0000)
    else $error("SFD did not open a frame");
  a_rx_runt_drop: assert property (@(posedge gmii_clk) disable iff (link_rst)
    (rx_end && runt) |=> wptr_q == $past(sof_ptr_q) && done_q == ($past(done_q) && !$past(rd_last)))
    else $error("runt frame kept");
  a_rx_addr_drop: assert property (@(posedge gmii_clk) disable iff (link_rst)
    (rx_end && !addr_ok && !done_q) |=> !done_q && !rx_wr)
    else $error("rejected address reached client");
  a_rx_crc_flag: assert property (@(posedge gmii_clk) disable iff (link_rst)
    (rx_end && rx_keep && !crc_ok) |=> fin_err_q && done_q)
    else $error("bad CRC not flagged");
  a_rx_stat_event: assert property (@(posedge gmii_clk) disable iff (link_rst)
    rx_end |=> stat_tgl_q != $past(stat_tgl_q))
    else $error("no statistics event for frame");

endmodule // eth_mac16_top

/* File: testbench/far_side_model.sv */
// Purpose: Far side model: client transmit FIFO plus a link looped back.
// Assumes: Every signal belongs to gmii_clk.
// Notes:   The loop lets each sent frame test the receiver as well.
`timescale 1ns/100ps
module far_side_model (
  input  wire logic        gmii_clk,
  input  wire logic        load,
  input  wire logic [15:0] da_word,
  input  wire logic [7:0]  len,
  input  wire logic [15:0] gmii_txd,
  input  wire logic        gmii_tx_en,
  input  wire logic        tx_rd,
  output logic             tx_pkt_avail = 1'b0,
  output logic [15:0]      tx_data,
  output logic             tx_eof,
  output logic [15:0]      gmii_rxd     = 16'h0000,
  output logic             gmii_rx_dv   = 1'b0
);
  logic [7:0]  idx_q = 8'h00;
  logic [15:0] word;
  // ----------------------------------------------------------------------
  // FIFO and link
  // ----------------------------------------------------------------------
  // Outside a packet the data is inverted so a stale word never looks valid.
  assign word    = (idx_q < 8'h03) ? da_word : {8'h00, idx_q};
  assign tx_data = tx_pkt_avail ? word : ~word;
  assign tx_eof  = tx_pkt_avail && (idx_q == len - 8'h01);
  always @(posedge gmii_clk) begin
    if (load) begin
      tx_pkt_avail <= 1'b1;
      idx_q        <= 8'h00;
    end else if (tx_rd && tx_pkt_avail) begin
      idx_q        <= idx_q + 8'h01;
      tx_pkt_avail <= !tx_eof;
    end
  end
  always @(posedge gmii_clk) begin
    gmii_rx_dv <= gmii_tx_en;
    gmii_rxd   <= gmii_tx_en ? gmii_txd : ~gmii_rxd;
  end
endmodule // far_side_model

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench of the MAC through a looped-back link.
// Assumes: Station address zero, so only broadcast passes unless promiscuous.
// Notes:   Rows hold ctrl, DA word, length, frame words and words delivered.
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic [7:0] ctrl; logic [15:0] da; logic [7:0] len; logic [7:0] fw; logic [7:0] nout;
  } row_t;
  localparam row_t ROWS [6] = '{
    '{8'h18, 16'hffff, 8'h04, 8'h20, 8'h1e}, '{8'h18, 16'hffff, 8'h28, 8'h2a, 8'h28},
    '{8'h18, 16'h1234, 8'h1e, 8'h20, 8'h00}, '{8'h1c, 16'hffff, 8'h1e, 8'h20, 8'h20},
    '{8'h08, 16'hffff, 8'h0a, 8'h0c, 8'h00}, '{8'h19, 16'h1234, 8'h1e, 8'h20, 8'h1e}};
  logic        clk = 1'b0, gmii_clk = 1'b0, sys_rst = 1'b1, cfg_wr = 1'b0, load = 1'b0;
  logic [3:0]  cfg_addr = 4'h6;
  logic [7:0]  cfg_wdata = 8'h18, len = 8'h01;
  logic [15:0] da = 16'h0000, gmii_txd, gmii_rxd, rx_data, tx_data, first_q;
  logic [21:0] stat_vec, stat_q;
  logic        stat_valid, gmii_tx_en, gmii_tx_er, gmii_rx_dv, rx_wr, rx_eof, rx_err;
  logic        tx_pkt_avail, tx_eof, tx_rd, err_q, rx_er = 1'b0;
  int          errors = 0, compares = 0, rx_n = 0, stat_n = 0, s0, i;
  always #10 clk = ~clk;
  always #62.5 gmii_clk = ~gmii_clk;
  eth_mac16_top i_dut (.clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .stat_valid(stat_valid), .stat_vec(stat_vec),
    .gmii_clk(gmii_clk), .gmii_rxd(gmii_rxd), .gmii_rx_dv(gmii_rx_dv), .gmii_rx_er(rx_er),
    .gmii_txd(gmii_txd), .gmii_tx_en(gmii_tx_en), .gmii_tx_er(gmii_tx_er), .rx_wr(rx_wr),
    .rx_data(rx_data), .rx_eof(rx_eof), .rx_err(rx_err), .tx_pkt_avail(tx_pkt_avail),
    .tx_data(tx_data), .tx_eof(tx_eof), .tx_rd(tx_rd));
  far_side_model i_far (.gmii_clk(gmii_clk), .load(load), .da_word(da), .len(len),
    .gmii_txd(gmii_txd), .gmii_tx_en(gmii_tx_en), .tx_rd(tx_rd),
    .tx_pkt_avail(tx_pkt_avail), .tx_data(tx_data), .tx_eof(tx_eof),
    .gmii_rxd(gmii_rxd), .gmii_rx_dv(gmii_rx_dv));
  // ----------------------------------------------------------------------
  // Monitors and tasks
  // ----------------------------------------------------------------------
  always @(posedge gmii_clk) begin
    if (rx_wr === 1'b1) begin
      if (rx_n == 0) first_q <= rx_data;
      if (rx_eof === 1'b1) err_q <= rx_err;
      rx_n <= rx_n + 1;
    end
  end
  always @(posedge clk) begin
    if (stat_valid === 1'b1) begin
      stat_q <= stat_vec;
      stat_n <= stat_n + 1;
    end
  end
  task automatic check(input string name, input logic [21:0] seen, input logic [21:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // A missing statistics event or a short delivery ends the run as a failure.
  task automatic wait_frame(input int nout);
    for (i = 0; i < 3000 && stat_n == s0; i++) @(posedge clk);
    for (i = 0; i < 100 && rx_n < nout; i++) @(posedge gmii_clk);
    repeat (8) @(posedge gmii_clk);
    if (stat_n == s0 || rx_n < nout) begin
      errors++;
      end_of_test();
    end
  endtask
  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  // Reset spans four link cycles so the slow domain sees it as well.
  initial begin
    repeat (4) @(posedge gmii_clk);
    @(posedge clk) sys_rst <= 1'b0;
    repeat (6) @(posedge gmii_clk);
    foreach (ROWS[r]) begin
      @(posedge clk) {cfg_wr, cfg_wdata} <= {1'b1, ROWS[r].ctrl};
      @(posedge clk) cfg_wr <= 1'b0;
      repeat (4) @(posedge gmii_clk);
      rx_n = 0;
      err_q = 1'b1;
      s0 = stat_n;
      @(posedge gmii_clk) {da, len, load} <= {ROWS[r].da, ROWS[r].len, 1'b1};
      @(posedge gmii_clk) load <= 1'b0;
      wait_frame(ROWS[r].nout);
      check("rx words", 22'(rx_n), 22'(ROWS[r].nout));
      check("byte count", 22'(stat_q[21:6]), 22'({ROWS[r].fw, 1'b0}));
      check("crc ok", 22'(stat_q[0]), 22'h000001);
      check("bcast", 22'(stat_q[1]), 22'(ROWS[r].da == 16'hffff));
      check("stat flags", 22'(stat_q[5:2]), 22'h000000);
      if (ROWS[r].nout != 0) begin
        check("first word", 22'(first_q), 22'(ROWS[r].da));
        check("eof err", 22'(err_q), 22'h000000);
      end
      $display("row %0d done", r);
    end
    // A link error inside a frame still delivers it, flagged on its last word.
    rx_n = 0;
    err_q = 1'b0;
    s0 = stat_n;
    @(posedge gmii_clk) {rx_er, load} <= 2'b11;
    @(posedge gmii_clk) load <= 1'b0;
    wait_frame(30);
    check("er flag", 22'(stat_q[5]), 22'h000001);
    check("er eof", 22'(err_q), 22'h000001);
    check("er words", 22'(rx_n), 22'h00001e);
    $display("error test done");
    @(posedge gmii_clk) {rx_er, load} <= 2'b01;
    @(posedge gmii_clk) load <= 1'b0;
    repeat (10) @(posedge gmii_clk);
    @(posedge clk) sys_rst <= 1'b1;
    repeat (4) @(posedge gmii_clk);
    check("reset outs", {gmii_tx_en, gmii_tx_er, tx_rd, rx_wr, rx_eof, rx_err, stat_valid,
                         stat_vec[14:0]}, 22'h000000);
    check("reset data", 22'(gmii_txd | rx_data | stat_vec[21:6]), 22'h000000);
    $display("reset test done");
    end_of_test();
  end
endmodule // tb_top
